// [rtl/pllcs_pkg.sv]
// shared constants and types for the clock synthesiser control block
package pllcs_pkg;
  localparam int  FB_DIV_W       = 7;
  localparam int  OUT_DIV_SEL_W  = 3;
  localparam int  OUT_DIV_MAX    = 64;
  localparam int  DELAY_W        = 8;
  localparam int  CLK_PERIOD_NS  = 8;
  localparam int  RELOCK_TIME_US = 50;
  localparam int  RELOCK_CYCLES  = (RELOCK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int  CFG_W          = 22;
  localparam int  PHASE_TAP_W    = 4;
  localparam int  PHASE_TAPS     = 16;
  localparam logic [FB_DIV_W-1:0]      FB_DIV_RST   = 7'h00;
  localparam logic [OUT_DIV_SEL_W-1:0] OUT_SEL_RST  = 3'h0;
  localparam logic [DELAY_W-1:0]       DELAY_RST    = 8'h00;
  localparam logic [1:0]               REF_SRC_RST  = 2'h0;

  typedef enum logic [1:0] {
    PLLCS_REF_PIN,
    PLLCS_REF_OSC,
    PLLCS_REF_FABRIC
  } pllcs_ref_src_t;

  // loop settings, also the serial reload image (lsb shifted first)
  typedef struct packed {
    logic [1:0]               refSrc;
    logic                     fbExternal;
    logic                     delayDynamic;
    logic [DELAY_W-1:0]       staticDelay;
    logic [OUT_DIV_SEL_W-1:0] outDivSel;
    logic [FB_DIV_W-1:0]      fbDiv;
  } pllcs_cfg_t;

  typedef struct packed {
    logic lowPowerFreeze;
    logic freezeEnableA;
    logic freezeEnableB;
  } pllcs_freeze_t;
endpackage : pllcs_pkg

// [rtl/pllcs_top.sv]
// behavioural control model of the on-chip clock synthesiser loop
// Overview of operation
// - The output divider divides the synthesized clock by 1 to 64 in power-of-two steps.
// - The synthesized clock runs at reference times the feedback divider ratio.
// - phase_aligned rises when lock is reached and drops on loss of lock.
// - Bypass low routes the loop clock out, bypass high routes the reference out.
// - ext_fb_in is loop feedback only when external feedback is selected.
// - fine_delay_ctrl steers output phase only in dynamic delay mode.
// - A phase shift, fixed or dynamic, advances or delays the output against the reference.
// - After a dynamic adjustment on the feedback output, relock waits relock_time.
// - After shifting, a loop reset pulse makes the loop relock with new settings.
// - Freeze request with both freeze enables holds both clock outputs static.
// - The fabric clock output has the same frequency as the global one.
// - The reference may come from a pin, the oscillator or fabric routing.
// - The global output is meant for the two preferred global buffers.
`timescale 1ns/10ps
module pllcs_top #(
  parameter int RELOCK_CNT = pllcs_pkg::RELOCK_CYCLES
) (
  input  wire logic                           core_clk,
  input  wire logic                           reset_n,
  input  wire logic                           ref_pin_clk,
  input  wire logic                           ref_osc_clk,
  input  wire logic                           ref_fabric_clk,
  input  wire logic                           bypass_sel,
  input  wire logic                           ext_fb_in,
  input  wire logic [pllcs_pkg::DELAY_W-1:0]  fine_delay_ctrl,
  input  wire pllcs_pkg::pllcs_freeze_t       freeze,
  input  wire pllcs_pkg::pllcs_cfg_t          boot_cfg,
  input  wire logic                           loop_reset_n,
  input  wire logic                           cfg_shift_clk,
  input  wire logic                           cfg_shift_data,
  output logic                                synth_clk_global,
  output logic                                synth_clk_fabric,
  output logic                                phase_aligned,
  output logic                                low_power_active,
  output pllcs_pkg::pllcs_cfg_t               active_cfg
);
  import pllcs_pkg::*;

  localparam int CNT_W = $clog2(RELOCK_CNT + 1);
  localparam logic [OUT_DIV_SEL_W-1:0] DIV_SEL_TOP = OUT_DIV_SEL_W'($clog2(OUT_DIV_MAX));

  typedef enum logic [1:0] {
    PLLCS_RESET,
    PLLCS_ACQUIRE,
    PLLCS_LOCKED
  } pllcs_state_t;

  pllcs_state_t state;
  pllcs_state_t next_state;
  pllcs_cfg_t   shiftImage;
  pllcs_cfg_t   next_shiftImage;
  pllcs_cfg_t   next_active_cfg;
  logic [CNT_W-1:0] lockCnt;
  logic [CNT_W-1:0] next_lockCnt;
  logic [OUT_DIV_MAX-1:0] outCnt;
  logic [OUT_DIV_MAX-1:0] next_outCnt;
  logic [FB_DIV_W-1:0] vcoCnt;
  logic [FB_DIV_W-1:0] next_vcoCnt;
  logic [DELAY_W-1:0]  delayQ;
  logic [DELAY_W-1:0]  next_delayQ;
  logic sclkQ;
  logic refQ;
  logic fbQ;
  logic vcoClk;
  logic next_vcoClk;
  logic loopOut;
  logic next_loopOut;
  logic next_global;
  logic next_phaseAligned;
  logic next_lowPower;
  logic refSel;
  logic refRise;
  logic sclkRise;
  logic fbEdge;
  logic [DELAY_W-1:0] delaySel;
  logic [CNT_W-1:0] cntPlusOne;
  logic [OUT_DIV_SEL_W-1:0] divIdx;
  logic [PHASE_TAPS-1:0]  loopHist;
  logic [PHASE_TAPS-1:0]  next_loopHist;
  logic [PHASE_TAP_W-1:0] tapSel;
  logic                   phaseOut;

  // phase shift: tap the loop clock history, up to 15 core cycles late;
  // on a periodic clock a late tap doubles as an early one
  always_comb begin
    tapSel        = delaySel[PHASE_TAP_W-1:0];
    next_loopHist = {loopHist[PHASE_TAPS-2:0], loopOut};
    if (tapSel == '0) begin
      phaseOut = loopOut;
    end else begin
      phaseOut = loopHist[tapSel - PHASE_TAP_W'(1)];
    end
  end

  always_comb begin
    unique case (pllcs_ref_src_t'(active_cfg.refSrc))
      PLLCS_REF_OSC:    refSel = ref_osc_clk;
      PLLCS_REF_FABRIC: refSel = ref_fabric_clk;
      default:          refSel = ref_pin_clk;
    endcase
  end

  always_comb begin
    refRise    = refSel & ~refQ;
    sclkRise   = cfg_shift_clk & ~sclkQ;
    cntPlusOne = lockCnt + CNT_W'(1);
    // selects past divide-by-64 are clamped
    divIdx     = (active_cfg.outDivSel > DIV_SEL_TOP) ? DIV_SEL_TOP : active_cfg.outDivSel;
    // internal vs external feedback edge
    fbEdge     = active_cfg.fbExternal ? (ext_fb_in & ~fbQ) : refRise;
    delaySel   = active_cfg.delayDynamic ? fine_delay_ctrl : active_cfg.staticDelay;
    next_delayQ = delaySel;
    next_shiftImage = shiftImage;
    if (sclkRise) begin
      next_shiftImage = {cfg_shift_data, shiftImage[CFG_W-1:1]};
    end
    next_active_cfg = active_cfg;
    if (!loop_reset_n) begin
      next_active_cfg = shiftImage;
    end
    // multiply: fb_div+1 vco toggles, one per core cycle, after each feedback edge
    next_vcoCnt = vcoCnt;
    next_vcoClk = vcoClk;
    if (fbEdge) begin
      next_vcoCnt = active_cfg.fbDiv;
      next_vcoClk = ~vcoClk;
    end else if (vcoCnt != '0) begin
      next_vcoCnt = vcoCnt - FB_DIV_W'(1);
      next_vcoClk = ~vcoClk;
    end
    next_outCnt  = outCnt;
    next_loopOut = loopOut;
    if (divIdx == '0) begin
      // divide by one: follow the vco itself
      next_loopOut = next_vcoClk;
    end else if (next_vcoClk & ~vcoClk) begin
      next_outCnt  = outCnt + OUT_DIV_MAX'(1);
      next_loopOut = next_outCnt[divIdx - OUT_DIV_SEL_W'(1)];
    end
    next_lowPower = freeze.lowPowerFreeze & freeze.freezeEnableA & freeze.freezeEnableB;
    next_global   = synth_clk_global;
    if (!next_lowPower) begin
      next_global = bypass_sel ? refSel : phaseOut;
    end
  end

  always_comb begin
    next_state        = state;
    next_lockCnt      = lockCnt;
    next_phaseAligned = 1'b0;
    unique case (state)
      PLLCS_RESET: begin
        next_lockCnt = '0;
        if (loop_reset_n) begin
          next_state = PLLCS_ACQUIRE;
        end
      end
      PLLCS_ACQUIRE: begin
        next_lockCnt = cntPlusOne;
        if (cntPlusOne >= CNT_W'(RELOCK_CNT)) begin
          next_state        = PLLCS_LOCKED;
          next_phaseAligned = 1'b1;
        end
      end
      PLLCS_LOCKED: begin
        next_phaseAligned = 1'b1;
        // phase change on feedback output drops lock
        if (active_cfg.delayDynamic && (delaySel != delayQ) && !active_cfg.fbExternal) begin
          next_state        = PLLCS_ACQUIRE;
          next_lockCnt      = '0;
          next_phaseAligned = 1'b0;
        end
      end
    endcase
    if (!loop_reset_n) begin
      next_state        = PLLCS_RESET;
      next_phaseAligned = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state            <= PLLCS_RESET;
      lockCnt          <= '0;
      shiftImage       <= boot_cfg;
      active_cfg       <= boot_cfg;
      vcoCnt           <= FB_DIV_RST;
      vcoClk           <= 1'b0;
      outCnt           <= '0;
      loopOut          <= 1'b0;
      loopHist         <= '0;
      delayQ           <= DELAY_RST;
      sclkQ            <= 1'b0;
      refQ             <= 1'b0;
      fbQ              <= 1'b0;
      synth_clk_global <= 1'b0;
      synth_clk_fabric <= 1'b0;
      phase_aligned    <= 1'b0;
      low_power_active <= 1'b0;
    end else begin
      state            <= next_state;
      lockCnt          <= next_lockCnt;
      shiftImage       <= next_shiftImage;
      active_cfg       <= next_active_cfg;
      vcoCnt           <= next_vcoCnt;
      vcoClk           <= next_vcoClk;
      outCnt           <= next_outCnt;
      loopOut          <= next_loopOut;
      loopHist         <= next_loopHist;
      delayQ           <= next_delayQ;
      sclkQ            <= cfg_shift_clk;
      refQ             <= refSel;
      fbQ              <= ext_fb_in;
      synth_clk_global <= next_global;
      synth_clk_fabric <= next_global;
      phase_aligned    <= next_phaseAligned;
      low_power_active <= next_lowPower;
    end
  end
endmodule : pllcs_top

// [test/pllcs_sva.sv]
// assertions on the ports of the clock synthesiser control block
`timescale 1ns/10ps
module pllcs_sva #(
  parameter int RELOCK_CNT = 8
) (
  input wire logic                         core_clk,
  input wire logic                         reset_n,
  input wire logic [pllcs_pkg::DELAY_W-1:0] fine_delay_ctrl,
  input wire pllcs_pkg::pllcs_freeze_t     freeze,
  input wire logic                         loop_reset_n,
  input wire logic                         synth_clk_global,
  input wire logic                         synth_clk_fabric,
  input wire logic                         phase_aligned,
  input wire logic                         low_power_active,
  input wire pllcs_pkg::pllcs_cfg_t        active_cfg
);
  import pllcs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_relock;
    (!phase_aligned) [*8] ##[1:3] phase_aligned;
  endsequence
  AST_RESET: assert property (disable iff (1'b0)
    !reset_n |=> !phase_aligned && !low_power_active) else $error("flags set in reset");
  AST_LOOP_RST: assert property (!loop_reset_n |=> !phase_aligned)
    else $error("lock kept in loop reset");
  AST_RELOCK: assert property ($rose(loop_reset_n) |-> s_relock)
    else $error("relock timing wrong");
  AST_SAME_CLK: assert property (synth_clk_global == synth_clk_fabric)
    else $error("clock outputs differ");
  AST_FREEZE: assert property (&freeze |-> ##[1:2] low_power_active)
    else $error("freeze not entered");
  AST_HOLD: assert property (low_power_active [*2] |-> $stable(synth_clk_global))
    else $error("output moved in freeze");
  AST_CFG: assert property (loop_reset_n && $past(loop_reset_n) |-> $stable(active_cfg))
    else $error("settings moved outside loop reset");
  AST_DYN: assert property (phase_aligned && active_cfg.delayDynamic &&
    !active_cfg.fbExternal && $changed(fine_delay_ctrl) |-> ##[0:2] !phase_aligned)
    else $error("lock kept after dynamic shift");
  AST_STATIC: assert property (phase_aligned && !active_cfg.delayDynamic &&
    !active_cfg.fbExternal && loop_reset_n |=> phase_aligned) else $error("lock lost");
endmodule : pllcs_sva

// [test/pllcs_user.sv]
// user fabric model: serial reload then loop reset pulse
`timescale 1ns/10ps
module pllcs_user (
  input  wire logic                  core_clk,
  input  wire logic                  go,
  input  wire pllcs_pkg::pllcs_cfg_t img,
  output logic                       shiftClk,
  output logic                       shiftData,
  output logic                       loopResetN,
  output logic                       done
);
  import pllcs_pkg::*;
  logic [CFG_W-1:0] word;
  initial begin
    {shiftClk, shiftData, loopResetN, done} = 4'h0;
    forever begin
      @(posedge go);
      done = 1'b0;
      word = CFG_W'(img);
      for (int i = 0; i < CFG_W; i++) begin
        @(posedge core_clk) #1 shiftClk = 1'b0;
        shiftData = word[i];
        @(posedge core_clk) #1 shiftClk = 1'b1;
      end
      @(posedge core_clk) #1 shiftClk = 1'b0;
      shiftData = ~shiftData;
      loopResetN = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 loopResetN = 1'b1;
      done = 1'b1;
    end
  end
endmodule : pllcs_user

// [test/pll_clock_synth_control_test.sv]
// self-checking bench for the clock synthesiser control block
`timescale 1ns/10ps
module pll_clock_synth_control_test;
  import pllcs_pkg::*;
  typedef struct packed {pllcs_cfg_t img; logic [7:0] tgl;} pllcs_row_t;
  pllcs_row_t rows [3] = '{{22'h016b7f, 8'h10}, {22'h1a9581, 8'h08}, {22'h240110, 8'h04}};
  logic core_clk, reset_n, bypassSel, extFb, go, done, sClk, sDat, lrN, sg, sf, pa, lpa, prev;
  logic ph;
  logic [7:0] fine;
  logic [7:0] cnt = 8'h00;
  pllcs_freeze_t frz;
  pllcs_cfg_t img, cfg;
  int num_errors, num_checks, tg;
  pllcs_top #(.RELOCK_CNT(8)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .ref_pin_clk(cnt[1]), .ref_osc_clk(cnt[2]), .ref_fabric_clk(cnt[3]),
    .bypass_sel(bypassSel), .ext_fb_in(extFb), .fine_delay_ctrl(fine), .freeze(frz),
    .boot_cfg(22'h0), .loop_reset_n(lrN), .cfg_shift_clk(sClk), .cfg_shift_data(sDat),
    .synth_clk_global(sg), .synth_clk_fabric(sf), .phase_aligned(pa),
    .low_power_active(lpa), .active_cfg(cfg));
  pllcs_user i_user (.core_clk(core_clk), .go(go), .img(img), .shiftClk(sClk),
    .shiftData(sDat), .loopResetN(lrN), .done(done));
  always @(posedge core_clk) cnt <= cnt + 8'h01;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    #2 num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task tcount(input int n);
    tg = 0;
    prev = sg;
    repeat (n) begin
      @(posedge core_clk);
      #1 if (sg !== prev) tg++;
      prev = sg;
    end
  endtask : tcount
  task load(input pllcs_cfg_t v);
    img = v;
    go = 1'b1;
    // let the model clear done from the last load first
    @(posedge core_clk);
    for (int k = 0; k < 200 && done !== 1'b1; k++) @(posedge core_clk);
    #1 go = 1'b0;
    chk(cfg, v);
    chk(pa, 1'b0);
    repeat (14) @(posedge core_clk);
    chk(pa, 1'b1);
  endtask : load
  initial begin
    {reset_n, bypassSel, extFb, go} = 4'h0;
    fine = 8'h00;
    frz = 3'h0;
    img = 22'h0;
    repeat (6) @(posedge core_clk);
    #1 reset_n = 1'b1;
    foreach (rows[i]) begin
      load(rows[i].img);
      bypassSel = 1'b1;
      repeat (4) @(posedge core_clk);
      tcount(32);
      chk(24'(tg), rows[i].tgl);
      #1 fine = fine + 8'h11;
      extFb = ~extFb;
      repeat (3) @(posedge core_clk);
      chk(pa, !(rows[i].img.delayDynamic && !rows[i].img.fbExternal));
      repeat (14) @(posedge core_clk);
      chk(pa, 1'b1);
    end
    #1 bypassSel = 1'b0;
    fine = 8'h00;
    load(22'h040003);
    tcount(32);
    chk(24'(tg), 24'h20);
    load(22'h040103);
    tcount(32);
    chk(24'(tg), 24'h08);
    ph = sg;
    fine = 8'h04;
    repeat (16) @(posedge core_clk);
    #1 chk(sg, !ph);
    chk(pa, 1'b1);
    #1 frz = 3'h7;
    repeat (3) @(posedge core_clk);
    chk(lpa, 1'b1);
    tcount(16);
    chk(24'(tg), 24'h0);
    #1 frz = 3'h6;
    repeat (3) @(posedge core_clk);
    chk(lpa, 1'b0);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    chk(pa, 1'b0);
    chk(cfg, 24'h0);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
    chk(pa, 1'b0);
    repeat (12) @(posedge core_clk);
    chk(pa, 1'b1);
    end_sim;
  end
  initial begin
    #20000 num_errors++;
    end_sim;
  end
endmodule : pll_clock_synth_control_test
bind pllcs_top pllcs_sva #(.RELOCK_CNT(RELOCK_CNT)) i_sva (.core_clk(core_clk),
  .reset_n(reset_n), .fine_delay_ctrl(fine_delay_ctrl), .freeze(freeze),
  .loop_reset_n(loop_reset_n), .synth_clk_global(synth_clk_global),
  .synth_clk_fabric(synth_clk_fabric), .phase_aligned(phase_aligned),
  .low_power_active(low_power_active), .active_cfg(active_cfg));
